// [src/ubf_uart.sv]
// Serial transceiver core: baud generator, frame formatter, transmitter and receiver.
// Assumes rx_i synchronous to clk_i and an Avalon-MM master that holds requests.
`timescale 1ns/1ps

// Behaviour
// - Free-running 8-bit divider, N from 0 to 255
// - Rate fH/(64(N+1)) slow, fH/(16(N+1)) fast
// - Frame: start, 8/9 data, stop bits
// - Reset format is 8 data, no parity, one stop
// - Independent directions, shared format, LSB first
// - Even, odd or no parity selectable
// - Two stop bits only for transmit
// - Data MSB marks address when detection enabled
// - Each pin used only when mode, global and its own direction enable set
// - Idle TX line stays high
// - Global disable releases TX and RX pins
// - Disable empties the data buffer
// - Disable clears enables/errors, sets idle flags
// - Disable keeps other configuration bits
// - Global disable aborts transfers at once
// - Ninth transmit bit taken from control field
// - Shifter reloads only after stop bit
// - Transmit needs enable, data and bit tick
// - Empty shifter takes written byte at once
// - Clearing transmit enable aborts the frame and returns the sequencer to idle
// - Shift registers not visible to software
// - Disabled direction leaves its pin undriven
// - Receiver x16 oversampling, three-sample majority
module ubf_uart
   import ubf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [4:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // Serial pins
   input wire logic rx_i,
   output logic tx_o,
   output logic tx_oe_o,
   output logic rx_sel_o
);

   // Frame with parity slotted into the last data position when enabled
   function automatic logic [8:0] ubf_frame(input logic [8:0] d, input logic nine,
                                            input logic pen, input logic odd);
      logic [8:0] r;
      logic p;
      r = nine ? d : {1'b0, d[7:0]};
      p = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
      if (pen && nine) begin
         r[8] = p;
      end else if (pen) begin
         r[7] = p;
      end
      return r;
   endfunction

   function automatic logic ubf_major(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // Control, bus and baud generator state
   ubf_ctrl_one_t c1_reg;
   ubf_ctrl_two_t c2_reg;
   logic [31:0] rdata_reg;
   logic [7:0] baud_reg, div_reg;
   logic [3:0] os_reg;
   logic [1:0] pre_reg;
   logic mode_reg, wait_reg, os_tick_reg, bit_tick_reg;
   // Transmit and receive state
   ubf_tx_state_t tx_st;
   ubf_rx_state_t rx_st;
   logic [8:0] tx_shift_reg, hold_reg, rx_shift_reg, rx_data_reg;
   logic [3:0] tx_cnt_reg, ph_reg, rx_cnt_reg;
   logic [2:0] samp_reg;
   logic hold_full_reg, txd_reg, tx_idle_reg, tx_pin_reg, tx_oe_reg, rx_sel_reg;
   logic rx_noise_reg, avail_reg, rx_idle_reg, ovr_reg, ferr_reg, perr_reg, nf_reg;
   // Decoded strobes
   logic acc, wr, tx_act, rx_act, data_wr, data_rd, rbit;
   logic [3:0] nbits;
   logic [7:0] status;
   logic [8:0] rx_aligned;

   assign acc = (read_i | write_i) & ~wait_reg;
   assign wr = write_i & acc;
   assign tx_act = mode_reg & c1_reg.serial_global_enable & c2_reg.transmitter_enable;
   assign rx_act = mode_reg & c1_reg.serial_global_enable & c2_reg.receiver_enable;
   assign data_wr = wr && address_i == ADDR_DATA && !hold_full_reg && c1_reg.serial_global_enable;
   assign data_rd = read_i && acc && address_i == ADDR_DATA;
   assign nbits = c1_reg.nine_bit_select ? BITS_NINE : BITS_EIGHT;
   assign rbit = ubf_major(samp_reg);
   assign rx_aligned = c1_reg.nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
   assign status = {perr_reg, nf_reg, ferr_reg, ovr_reg, rx_idle_reg, avail_reg, tx_idle_reg, ~hold_full_reg};

   // Bus answer: one wait cycle, then the access completes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= !((read_i || write_i) && wait_reg);
         if (read_i && wait_reg) begin
            case (address_i)
               ADDR_CTRL_ONE: rdata_reg <= {24'h00_0000, c1_reg[7:2], rx_data_reg[8], 1'b0};
               ADDR_CTRL_TWO: rdata_reg <= {24'h00_0000, c2_reg};
               ADDR_BAUD: rdata_reg <= {24'h00_0000, baud_reg};
               ADDR_DATA: rdata_reg <= {24'h00_0000, rx_data_reg[7:0]};
               ADDR_STATUS: rdata_reg <= {24'h00_0000, status};
               ADDR_MODE: rdata_reg <= {31'h0000_0000, mode_reg};
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control registers; clearing the global enable drops the direction enables and break
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c1_reg <= CTRL_ONE_RST;
         c2_reg <= CTRL_TWO_RST;
         baud_reg <= BAUD_RST;
         mode_reg <= 1'b0;
      end else if (wr) begin
         case (address_i)
            ADDR_CTRL_ONE: begin
               c1_reg <= writedata_i[7:0];
               c1_reg.rx_ninth_bit <= 1'b0;
               if (!writedata_i[7]) begin
                  c1_reg.send_break <= 1'b0;
                  c2_reg.transmitter_enable <= 1'b0;
                  c2_reg.receiver_enable <= 1'b0;
               end
            end
            ADDR_CTRL_TWO: c2_reg <= writedata_i[7:0];
            ADDR_BAUD: baud_reg <= writedata_i[7:0];
            ADDR_MODE: mode_reg <= writedata_i[0];
            default: ;
         endcase
      end
   end

   // Baud generator: prescaler, N+1 divider, x16 oversample and bit tick
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_reg <= 2'h0;
         div_reg <= 8'h00;
         os_reg <= 4'h0;
         {os_tick_reg, bit_tick_reg} <= 2'h0;
      end else begin
         os_tick_reg <= 1'b0;
         bit_tick_reg <= os_tick_reg && os_reg == OS_LAST;
         if (os_tick_reg) begin
            os_reg <= os_reg + 4'h1;
         end
         if (pre_reg == (c2_reg.high_speed_select ? PRE_TOP_HIGH : PRE_TOP_LOW)) begin
            pre_reg <= 2'h0;
            if (div_reg >= baud_reg) begin
               div_reg <= 8'h00;
               os_tick_reg <= 1'b1;
            end else begin
               div_reg <= div_reg + 8'h01;
            end
         end else begin
            pre_reg <= pre_reg + 2'h1;
         end
      end
   end

   // Transmitter: holding register, shifter and frame sequencer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_st <= TX_IDLE;
         {tx_shift_reg, hold_reg} <= 18'h0_0000;
         hold_full_reg <= 1'b0;
         tx_cnt_reg <= 4'h0;
         txd_reg <= 1'b1;
         tx_idle_reg <= 1'b1;
      end else if (!c1_reg.serial_global_enable) begin
         tx_st <= TX_IDLE;
         hold_full_reg <= 1'b0;
         txd_reg <= 1'b1;
         tx_idle_reg <= 1'b1;
      end else begin
         if (data_wr) begin
            hold_reg <= writedata_i[8:0];
            hold_full_reg <= 1'b1;
            tx_idle_reg <= 1'b0;
         end
         if (!tx_act) begin
            tx_st <= TX_IDLE;
            txd_reg <= 1'b1;
         end else begin
            case (tx_st)
               TX_IDLE: begin
                  if (hold_full_reg) begin
                     tx_shift_reg <= ubf_frame({c1_reg.tx_ninth_bit, hold_reg[7:0]}, c1_reg.nine_bit_select,
                                               c1_reg.parity_enable, c1_reg.parity_type);
                     hold_full_reg <= 1'b0;
                     tx_st <= TX_READY;
                  end
               end
               TX_READY: begin
                  if (bit_tick_reg) begin
                     txd_reg <= 1'b0;
                     tx_st <= TX_START;
                  end
               end
               TX_START: begin
                  if (bit_tick_reg) begin
                     txd_reg <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                     tx_cnt_reg <= 4'h1;
                     tx_st <= TX_DATA;
                  end
               end
               TX_DATA: begin
                  if (bit_tick_reg && tx_cnt_reg == nbits) begin
                     txd_reg <= 1'b1;
                     tx_cnt_reg <= 4'h0;
                     tx_st <= TX_STOP;
                  end else if (bit_tick_reg) begin
                     txd_reg <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                     tx_cnt_reg <= tx_cnt_reg + 4'h1;
                  end
               end
               TX_STOP: begin
                  if (bit_tick_reg && c1_reg.two_stop_select && tx_cnt_reg == 4'h0) begin
                     tx_cnt_reg <= 4'h1;
                  end else if (bit_tick_reg && hold_full_reg) begin
                     tx_shift_reg <= ubf_frame({c1_reg.tx_ninth_bit, hold_reg[7:0]}, c1_reg.nine_bit_select,
                                               c1_reg.parity_enable, c1_reg.parity_type);
                     hold_full_reg <= 1'b0;
                     txd_reg <= 1'b0;
                     tx_st <= TX_START;
                  end else if (bit_tick_reg) begin
                     tx_idle_reg <= 1'b1; // Set wins over a same-cycle data write
                     tx_st <= TX_IDLE;
                  end
               end
               default: tx_st <= TX_IDLE;
            endcase
         end
      end
   end

   // Pin drivers: break forces low, idle line high, undriven when disabled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_pin_reg <= 1'b1;
         tx_oe_reg <= 1'b0;
         rx_sel_reg <= 1'b0;
      end else begin
         tx_pin_reg <= txd_reg & ~c1_reg.send_break;
         tx_oe_reg <= tx_act;
         rx_sel_reg <= rx_act;
      end
   end

   // Receiver: start detect, majority vote, shift, store and flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_st <= RX_IDLE;
         {ph_reg, rx_cnt_reg} <= 8'h00;
         samp_reg <= 3'h7;
         {rx_shift_reg, rx_data_reg} <= 18'h0_0000;
         rx_noise_reg <= 1'b0;
         rx_idle_reg <= 1'b1;
         {avail_reg, ovr_reg, ferr_reg, perr_reg, nf_reg} <= 5'h00;
      end else if (!c1_reg.serial_global_enable) begin
         rx_st <= RX_IDLE;
         rx_idle_reg <= 1'b1;
         {avail_reg, ovr_reg, ferr_reg, perr_reg, nf_reg} <= 5'h00;
      end else begin
         // Data read clears the flags; a same-cycle store below wins
         if (data_rd) begin
            {avail_reg, ovr_reg, ferr_reg, perr_reg, nf_reg} <= 5'h00;
         end
         if (!rx_act) begin
            rx_st <= RX_IDLE;
            rx_idle_reg <= 1'b1;
         end else if (os_tick_reg) begin
            ph_reg <= ph_reg + 4'h1;
            if (ph_reg >= VOTE_FIRST && ph_reg <= VOTE_LAST) begin
               samp_reg <= {samp_reg[1:0], rx_i};
            end
            case (rx_st)
               RX_IDLE: begin
                  ph_reg <= 4'h0;
                  if (!rx_i) begin
                     rx_st <= RX_START;
                     rx_idle_reg <= 1'b0;
                     rx_noise_reg <= 1'b0;
                  end
               end
               RX_START: begin
                  if (ph_reg == OS_LAST && rbit) begin
                     rx_st <= RX_IDLE;
                     rx_idle_reg <= 1'b1;
                  end else if (ph_reg == OS_LAST) begin
                     rx_cnt_reg <= 4'h0;
                     rx_st <= RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (ph_reg == OS_LAST) begin
                     rx_shift_reg <= {rbit, rx_shift_reg[8:1]};
                     rx_noise_reg <= rx_noise_reg | ~(&samp_reg | ~|samp_reg);
                     rx_cnt_reg <= rx_cnt_reg + 4'h1;
                     if (rx_cnt_reg == nbits - 4'h1) begin
                        rx_st <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (ph_reg == OS_LAST) begin
                     rx_st <= RX_IDLE;
                     rx_idle_reg <= 1'b1;
                     if (c2_reg.address_detect && !rx_aligned[nbits - 4'h1]) begin
                        rx_noise_reg <= 1'b0;
                     end else if (avail_reg && !data_rd) begin
                        ovr_reg <= 1'b1;
                     end else begin
                        rx_data_reg <= rx_aligned;
                        avail_reg <= 1'b1;
                        ferr_reg <= ~rbit;
                        nf_reg <= rx_noise_reg;
                        perr_reg <= c1_reg.parity_enable && ubf_frame(rx_aligned, c1_reg.nine_bit_select,
                                    1'b1, c1_reg.parity_type) != rx_aligned;
                     end
                  end
               end
               default: rx_st <= RX_IDLE;
            endcase
         end
      end
   end

   assign readdata_o = rdata_reg;
   assign waitrequest_o = wait_reg;
   assign tx_o = tx_pin_reg;
   assign tx_oe_o = tx_oe_reg;
   assign rx_sel_o = rx_sel_reg;

   // Helper: bit tick spacing, trusted only from the third tick after a rate change (first period may be partial)
   logic [15:0] gap_reg, expect_gap;
   logic clean_reg, armed_reg;
   assign expect_gap = ({8'h00, baud_reg} + 16'h0001) * OS_PER_BIT * (c2_reg.high_speed_select ? 16'h0001 : PRE_LOW);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_reg <= 16'h0000;
         {clean_reg, armed_reg} <= 2'h0;
      end else begin
         gap_reg <= bit_tick_reg ? 16'h0000 : gap_reg + 16'h0001;
         if (wr && (address_i == ADDR_BAUD || address_i == ADDR_CTRL_TWO)) begin
            clean_reg <= 1'b0;
            armed_reg <= 1'b0;
         end else if (bit_tick_reg) begin
            clean_reg <= armed_reg;
            armed_reg <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_bit_period: assert property (bit_tick_reg && clean_reg && !wr |-> gap_reg == expect_gap - 16'h0001)
      else $error("bit tick spacing wrong");
   a_idle_high: assert property (tx_st == TX_IDLE && !c1_reg.send_break |=> tx_o)
      else $error("idle line not high");
   a_start_low: assert property (tx_act && tx_st == TX_READY && bit_tick_reg |=> ##1 !tx_o)
      else $error("start bit not low");
   a_stop_high: assert property (tx_act && tx_st == TX_STOP && !c1_reg.send_break |=> tx_o)
      else $error("stop bit not high");
   a_lsb_first: assert property (tx_act && tx_st == TX_START && bit_tick_reg |=> txd_reg == $past(tx_shift_reg[0]))
      else $error("first data bit not lsb");
   a_tx_abort: assert property (!tx_act |=> tx_st == TX_IDLE)
      else $error("transmitter kept running");
   a_imm_load: assert property (tx_act && tx_st == TX_IDLE && hold_full_reg |=> tx_st == TX_READY && !hold_full_reg)
      else $error("byte not moved to shifter");
   a_disable_flags: assert property (!c1_reg.serial_global_enable |=> tx_idle_reg && rx_idle_reg && !avail_reg
                                     && !hold_full_reg && !ferr_reg)
      else $error("disable flags wrong");
   a_pin_release: assert property (!c1_reg.serial_global_enable |=> !tx_oe_o && !rx_sel_o)
      else $error("pins not released");
   a_keep_baud: assert property (!(wr && address_i == ADDR_BAUD) |=> $stable(baud_reg))
      else $error("divisor changed");
   a_bus_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("bus answer late");
   c_frame_done: cover property (tx_st == TX_STOP && bit_tick_reg ##1 tx_st == TX_IDLE);
   c_abort_mid: cover property (tx_st == TX_DATA ##1 !c1_reg.serial_global_enable);
   c_rx_store: cover property (!avail_reg ##1 avail_reg);
endmodule

// [shared/ubf_pkg.sv]
// Constants, register map and field layouts of the serial transceiver core.
// Assumes a 50 MHz system clock and an Avalon-MM slave with byte addresses.
package ubf_pkg;
   // Register byte offsets
   localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
   localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
   localparam logic [4:0] ADDR_BAUD = 5'h08;
   localparam logic [4:0] ADDR_DATA = 5'h0c;
   localparam logic [4:0] ADDR_STATUS = 5'h10;
   localparam logic [4:0] ADDR_MODE = 5'h14;
   // Reset values
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   // Prescaler top counts: low speed divides by 4, high speed by 1 ahead of the x16 oversampler
   localparam logic [1:0] PRE_TOP_LOW = 2'h3;
   localparam logic [1:0] PRE_TOP_HIGH = 2'h0;
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_LAST = 4'h9;
   localparam logic [15:0] OS_PER_BIT = 16'h0010;
   localparam logic [15:0] PRE_LOW = 16'h0004;
   // Data bit counts
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   // Status bit positions
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_IDLE = 1;
   localparam int ST_RX_AVAIL = 2;
   localparam int ST_RX_IDLE = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_FRAMING = 5;
   localparam int ST_NOISE = 6;
   localparam int ST_PARITY = 7;

   typedef struct packed {
      logic serial_global_enable;
      logic nine_bit_select;
      logic parity_enable;
      logic parity_type;
      logic two_stop_select;
      logic send_break;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
   } ubf_ctrl_one_t;

   typedef struct packed {
      logic transmitter_enable;
      logic receiver_enable;
      logic high_speed_select;
      logic address_detect;
      logic [3:0] spare;
   } ubf_ctrl_two_t;

   typedef enum logic [2:0] {TX_IDLE, TX_READY, TX_START, TX_DATA, TX_STOP} ubf_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubf_rx_state_t;
endpackage

// [verif/ubf_remote.sv]
// Remote serial device model: frames bytes on its output line and decodes the device transmit line.
// Assumes an idle-high line with a pull-up and a bit period counted in system clocks.
`timescale 1ns/1ps
module ubf_remote (
   // Clock
   input wire logic clk_i,
   // Serial lines
   input wire logic line_i,
   output logic line_o
);
   initial line_o = 1'b1;

   // Sends start, data LSB first, one stop; called just after a rising edge
   task automatic send(input logic [8:0] val, input int nbits, input int period);
      line_o <= 1'b0;
      repeat (period) @(posedge clk_i);
      for (int i = 0; i < nbits; i++) begin
         line_o <= val[i];
         repeat (period) @(posedge clk_i);
      end
      line_o <= 1'b1;
      repeat (period) @(posedge clk_i);
   endtask

   // Waits for a start bit, then samples every bit at its centre
   task automatic recv(input int nbits, input int period, output logic [8:0] val, output logic stop_ok);
      val = '0;
      while (line_i !== 1'b0) @(posedge clk_i);
      repeat (period / 2) @(posedge clk_i);
      for (int i = 0; i < nbits; i++) begin
         repeat (period) @(posedge clk_i);
         val[i] = line_i;
      end
      repeat (period) @(posedge clk_i);
      stop_ok = (line_i === 1'b1);
   endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the serial transceiver core: register bus tasks and frame scenarios.
// Assumes the remote device model on the serial lines and a pull-up on the released transmit pin.
`timescale 1ns/1ps
module testbench;
   import ubf_pkg::*;
   logic clk_i, rst_i, read_i, write_i, rx_i, tx_o, tx_oe_o, rx_sel_o, waitrequest_o, tx_line, stop_ok;
   logic [4:0] address_i;
   logic [31:0] writedata_i, readdata_o, rd;
   logic [8:0] got;
   logic [7:0] c1 [4] = '{8'h80, 8'hc1, 8'ha0, 8'hb0};
   logic [7:0] dv [4] = '{8'h55, 8'ha3, 8'h13, 8'h13};
   logic [8:0] ev [4] = '{9'h055, 9'h1a3, 9'h093, 9'h013};
   int nb [4] = '{8, 9, 8, 8};
   int bad_count, total_checks;

   // Released pin is pulled high
   assign tx_line = tx_oe_o ? tx_o : 1'b1;

   ubf_uart ubf_uart_inst (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .rx_i(rx_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .rx_sel_o(rx_sel_o));
   ubf_remote ubf_remote_inst (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_i));

   // Clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
      total_checks++;
      if (got_v !== exp_v) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr_en, input logic [4:0] addr, input logic [31:0] data);
      write_i <= wr_en;
      read_i <= ~wr_en;
      address_i <= addr;
      writedata_i <= data;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_i);
      rd = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [4:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data);
   endtask

   task automatic rdchk(input logic [4:0] addr, input logic [31:0] exp_v);
      bus(1'b0, addr, 32'h0000_0000);
      check(rd, exp_v);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (40000) @(posedge clk_i);
      bad_count++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      read_i = 1'b0;
      write_i = 1'b0;
      address_i = 5'h00;
      writedata_i = 32'h0000_0000;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset state and unmapped place
      rdchk(ADDR_CTRL_ONE, 32'h0000_0000);
      rdchk(ADDR_STATUS, 32'h0000_000b);
      rdchk(5'h1c, 32'h0000_0000);
      check({30'h0000_0000, tx_oe_o, rx_sel_o}, 32'h0000_0000);
      // Enable at high speed, N = 0, sixteen clocks a bit
      wr(ADDR_MODE, 32'h0000_0001);
      wr(ADDR_BAUD, 32'h0000_0000);
      wr(ADDR_CTRL_TWO, 32'h0000_00e0);
      wr(ADDR_CTRL_ONE, 32'h0000_0080);
      repeat (2) @(posedge clk_i);
      check({29'h0000_0000, tx_oe_o, rx_sel_o, tx_o}, 32'h0000_0007);
      // Frame formats: plain, ninth bit, even and odd parity
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL_ONE, {24'h00_0000, c1[k]});
         fork
            wr(ADDR_DATA, {24'h00_0000, dv[k]});
            ubf_remote_inst.recv(nb[k], 16, got, stop_ok);
         join
         check({23'h00_0000, got}, {23'h00_0000, ev[k]});
         check({31'h0000_0000, stop_ok}, 32'h0000_0001);
         repeat (16) @(posedge clk_i);
      end
      // Back-to-back bytes with two stop bits: first stop read as a ninth bit, second as the stop
      wr(ADDR_CTRL_ONE, 32'h0000_0088);
      fork
         begin
            wr(ADDR_DATA, 32'h0000_0011);
            wr(ADDR_DATA, 32'h0000_0022);
         end
         begin
            ubf_remote_inst.recv(9, 16, got, stop_ok);
            check({23'h00_0000, got}, 32'h0000_0111);
            check({31'h0000_0000, stop_ok}, 32'h0000_0001);
            ubf_remote_inst.recv(9, 16, got, stop_ok);
            check({23'h00_0000, got}, 32'h0000_0122);
         end
      join
      repeat (24) @(posedge clk_i);
      rdchk(ADDR_STATUS, 32'h0000_000b);
      // Reception with the same format
      ubf_remote_inst.send(9'h0a5, 8, 16);
      repeat (20) @(posedge clk_i);
      rdchk(ADDR_STATUS, 32'h0000_000f);
      rdchk(ADDR_DATA, 32'h0000_00a5);
      // A low ninth slot lands where the receiver wants its single stop bit
      ubf_remote_inst.send(9'h0a5, 9, 16);
      repeat (20) @(posedge clk_i);
      rdchk(ADDR_STATUS, 32'h0000_002f);
      rdchk(ADDR_DATA, 32'h0000_00a5);
      // Address detection drops a frame with a clear MSB and keeps one with it set
      wr(ADDR_CTRL_TWO, 32'h0000_00f0);
      ubf_remote_inst.send(9'h025, 8, 16);
      repeat (20) @(posedge clk_i);
      rdchk(ADDR_STATUS, 32'h0000_000b);
      ubf_remote_inst.send(9'h0a5, 8, 16);
      repeat (20) @(posedge clk_i);
      rdchk(ADDR_DATA, 32'h0000_00a5);
      // Low speed, N = 1: 128 clocks a bit
      wr(ADDR_BAUD, 32'h0000_0001);
      wr(ADDR_CTRL_TWO, 32'h0000_00cf);
      fork
         wr(ADDR_DATA, 32'h0000_003c);
         ubf_remote_inst.recv(8, 128, got, stop_ok);
      join
      check({23'h00_0000, got}, 32'h0000_003c);
      repeat (128) @(posedge clk_i);
      // Global disable in mid-frame
      fork
         wr(ADDR_DATA, 32'h0000_0000);
         while (tx_line !== 1'b0) @(posedge clk_i);
      join
      wr(ADDR_CTRL_ONE, 32'h0000_0000);
      repeat (2) @(posedge clk_i);
      check({29'h0000_0000, tx_oe_o, rx_sel_o, tx_line}, 32'h0000_0001);
      rdchk(ADDR_STATUS, 32'h0000_000b);
      rdchk(ADDR_CTRL_TWO, 32'h0000_000f);
      rdchk(ADDR_BAUD, 32'h0000_0001);
      wr(ADDR_DATA, 32'h0000_0077);
      rdchk(ADDR_STATUS, 32'h0000_000b);
      // Re-enable and send with the kept rate
      wr(ADDR_CTRL_TWO, 32'h0000_00c0);
      wr(ADDR_CTRL_ONE, 32'h0000_0080);
      fork
         wr(ADDR_DATA, 32'h0000_005a);
         ubf_remote_inst.recv(8, 128, got, stop_ok);
      join
      check({23'h00_0000, got}, 32'h0000_005a);
      report_and_stop();
   end
endmodule
